/* ppc_core.sv */
// parallel port register core: host byte ports, status, control, epp
`timescale 1ns/1ns
module ppc_core (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire ppc_pkg::ppc_mode_t mode_in,
    input  wire logic [2:0]        host_addr_in,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe_n_out,
    input  wire logic              host_write_strobe_n_in,
    input  wire logic              host_read_strobe_n_in,
    output logic                   host_ready_out,
    output logic                   irq_out,
    input  wire logic [7:0]        port_data_lines_in,
    output logic      [7:0]        port_data_lines_out,
    output logic                   port_data_lines_oe_n_out,
    input  wire logic              printer_fault_pin_in,
    input  wire logic              online_in,
    input  wire logic              paper_out_in,
    input  wire logic              char_accept_in,
    input  wire logic              busy_in,
    input  wire logic              epp_wait_n_in,
    output logic                   print_pulse_pin_out,
    output logic                   line_advance_pin_out,
    output logic                   printer_reinit_out,
    output logic                   device_choose_pin_out,
    output logic                   epp_data_strobe_n_out,
    output logic                   epp_addr_strobe_n_out,
    output logic                   epp_write_n_out
);
    import ppc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int SW = 27;
    localparam logic [SW-1:0] SYNC_INIT = {2'b11, 25'h0000001};
    logic [SW-1:0] sync_q;           // synchronised pin group
    logic          wr_n_s;           // host write strobe, synced
    logic          rd_n_s;           // host read strobe, synced
    logic [2:0]    addr_s;           // host address, synced
    logic [7:0]    hdata_s;          // host data bus, synced
    logic [7:0]    pdata_s;          // port lines, synced
    logic          fault_s;
    logic          online_s;
    logic          paper_s;
    logic          accept_s;
    logic          busy_s;
    logic          wait_n_s;         // peripheral wait, synced

    // every host bus and printer pin crosses two flops first; mode_in is used as it comes
    ppc_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({host_write_strobe_n_in, host_read_strobe_n_in,
                      host_addr_in, host_data_in, port_data_lines_in,
                      printer_fault_pin_in, online_in, paper_out_in,
                      char_accept_in, busy_in, epp_wait_n_in}),
        .sync_out   (sync_q)
    );
    assign {wr_n_s, rd_n_s, addr_s, hdata_s, pdata_s, fault_s, online_s,
            paper_s, accept_s, busy_s, wait_n_s} = sync_q;

    ////////////////////////////////////////////////////////////////////
    // strobe edges
    logic wr_n_d;      // write strobe, one cycle older
    logic rd_n_d;      // read strobe, one cycle older
    logic accept_d;    // accept input, one cycle older
    logic wr_end;      // write strobe rising: data taken here
    logic rd_start;    // read strobe falling: sample here
    logic accept_rise;
    logic is_epp;
    logic reachable;   // addressed port exists in this mode

    // edge history
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wr_n_d   <= 1'b1;
            rd_n_d   <= 1'b1;
            accept_d <= 1'b0;
        end else begin
            wr_n_d   <= wr_n_s;
            rd_n_d   <= rd_n_s;
            accept_d <= accept_s;
        end
    end

    assign wr_end      = wr_n_s && !wr_n_d;
    assign rd_start    = !rd_n_s && rd_n_d;
    assign accept_rise = accept_s && !accept_d;
    assign is_epp      = (mode_in == MODE_EPP);
    assign reachable   = !epp_only(addr_s) || is_epp;

    ////////////////////////////////////////////////////////////////////
    // data and control registers
    logic [7:0]          data_latch;  // port_data_latch
    logic [CT_WIDTH-1:0] ctrl;        // printer_control bits 0..5
    logic                wr_data;
    logic                wr_status;
    logic                wr_ctrl;

    assign wr_data   = wr_end && (addr_s == OFS_DATA);
    assign wr_status = wr_end && (addr_s == OFS_STATUS) && is_epp;
    assign wr_ctrl   = wr_end && (addr_s == OFS_CTRL);

    // data latch takes the bus byte at the end of the write
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            data_latch <= DATA_RST;
        end else if (wr_data) begin
            data_latch <= hdata_s;
        end
    end

    // only six control bits have storage; 6 and 7 do not exist
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= hdata_s[CT_WIDTH-1:0];
        end
    end

    // printer side control pins
    assign print_pulse_pin_out   = ~ctrl[CT_PRINT];
    assign line_advance_pin_out  = ~ctrl[CT_LINE_ADV];
    assign printer_reinit_out    = ctrl[CT_REINIT];
    assign device_choose_pin_out = ~ctrl[CT_CHOOSE];

    ////////////////////////////////////////////////////////////////////
    // interrupt: one clock pulse per accept rising edge while the irq allow control bit is set
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= ctrl[CT_IRQ_ALLOW] && accept_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // enhanced cycle request buffer and engine
    logic              req_valid;   // host asks for an enhanced cycle
    logic              req_ready;   // buffer can take it
    logic [ENT_W-1:0]  req_ent;
    logic              eng_valid;
    logic              eng_ready;
    logic [ENT_W-1:0]  eng_ent;
    logic [ENT_W-1:0]  cur;          // entry in flight
    ppc_eng_t          eng_state;
    logic [TCNT_W-1:0] tcnt;         // watchdog count
    logic              timeout_hit;
    logic              eng_done;     // read cycle finished this clock
    logic [7:0]        epp_rd_byte;  // byte caught from the lines
    logic              rd_wait;      // host read waits on the engine
    logic              cur_write;

    // writes push on strobe end, reads push on strobe start
    assign req_valid = is_epp && epp_only(addr_s) && (wr_end || rd_start);
    assign req_ent   = {addr_s == OFS_EADDR, wr_end, hdata_s};
    // with direction set to input a write runs as a read
    assign cur_write = cur[8] && !ctrl[CT_DIR];
    assign eng_ready = (eng_state == ES_IDLE);
    assign timeout_hit = (eng_state == ES_STROBE) && !wait_n_s
                         && (tcnt == TIMEOUT_LAST);

    ppc_buf2 #(.W(ENT_W)) u_buf (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (req_valid),
        .in_ready_out  (req_ready),
        .in_data_in    (req_ent),
        .out_valid_out (eng_valid),
        .out_ready_in  (eng_ready),
        .out_data_out  (eng_ent)
    );

    // engine: strobe until the peripheral releases wait, or give up
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            eng_state   <= ES_IDLE;
            cur         <= '0;
            tcnt        <= '0;
            eng_done    <= 1'b0;
            epp_rd_byte <= 8'h00;
        end else begin
            eng_done <= 1'b0;
            case (eng_state)
                ES_IDLE: begin
                    tcnt <= '0;
                    if (eng_valid) begin
                        cur       <= eng_ent;
                        eng_state <= ES_STROBE;
                    end
                end
                ES_STROBE: begin
                    tcnt <= tcnt + 1'b1;
                    if (wait_n_s) begin
                        epp_rd_byte <= pdata_s;
                        eng_done    <= !cur_write;
                        eng_state   <= ES_FINISH;
                    end else if (timeout_hit) begin
                        eng_done  <= !cur_write;
                        eng_state <= ES_IDLE;
                    end
                end
                ES_FINISH: begin
                    eng_state <= ES_IDLE;
                end
                default: begin
                    eng_state <= ES_IDLE;
                end
            endcase
        end
    end

    // strobes and write line from the engine state
    assign epp_data_strobe_n_out = !((eng_state == ES_STROBE) && !cur[9]);
    assign epp_addr_strobe_n_out = !((eng_state == ES_STROBE) && cur[9]);
    assign epp_write_n_out       = !((eng_state != ES_IDLE) && cur_write);

    ////////////////////////////////////////////////////////////////////
    // timeout flag: hardware set beats a software clear
    logic tmo_flag; // epp_timeout_flag

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tmo_flag <= 1'b0;
        end else if (timeout_hit) begin
            tmo_flag <= 1'b1;
        end else if (wr_status && hdata_s[ST_TIMEOUT]) begin
            tmo_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // host read path
    logic [7:0] status_now; // printer_state as it stands
    logic [7:0] next_rd;    // value captured at read start

    // bits 1 and 2 have no storage
    always_comb begin
        status_now               = 8'h00;
        status_now[ST_TIMEOUT]   = tmo_flag && is_epp;
        status_now[ST_FAULT]     = fault_s;
        status_now[ST_ONLINE]    = online_s;
        status_now[ST_PAPER_OUT] = paper_s;
        status_now[ST_ACCEPT]    = accept_s;
        status_now[ST_NOT_OCC]   = !busy_s;
    end

    // mux of every port; enhanced data comes later from the engine
    always_comb begin
        case (addr_s)
            OFS_DATA:   next_rd = pdata_s;
            OFS_STATUS: next_rd = status_now;
            OFS_CTRL:   next_rd = {2'b00, ctrl};
            default:    next_rd = reachable ? 8'h00 : UNMAP_RD;
        endcase
    end

    // output latch holds for the read cycle; an enhanced read reloads it once when the engine finishes
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            host_data_out <= 8'h00;
            rd_wait       <= 1'b0;
        end else if (rd_start) begin
            host_data_out <= next_rd;
            rd_wait       <= req_valid;
        end else if (eng_done && rd_wait) begin
            host_data_out <= epp_rd_byte;
            rd_wait       <= 1'b0;
        end
    end

    // bus driven only while the read strobe is low
    assign host_data_oe_n_out = rd_n_s;

    // stall the host while a read waits or the buffer is full;
    // wiring this to the host bus is up to the integrator
    assign host_ready_out = req_ready && !rd_wait && !req_valid;

    ////////////////////////////////////////////////////////////////////
    // port data lines
    logic engine_reads; // enhanced read holds the lines released

    assign engine_reads = (eng_state != ES_IDLE) && !cur_write;
    assign port_data_lines_out = (eng_state != ES_IDLE)
                                 ? cur[7:0] : data_latch;
    always_comb begin
        if (mode_in == MODE_PRINTER) begin
            port_data_lines_oe_n_out = 1'b0;
        end else begin
            port_data_lines_oe_n_out = ctrl[CT_DIR] || engine_reads;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_stuck_strobe;
        (eng_state == ES_STROBE) && !wait_n_s && (tcnt == TIMEOUT_LAST);
    endsequence

    a_timeout_sets: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) s_stuck_strobe |=> tmo_flag
            && (eng_state == ES_IDLE))
        else $error("watchdog did not set flag and abort");
    a_flag_clears: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        wr_status && hdata_s[ST_TIMEOUT] && !timeout_hit |=> !tmo_flag)
        else $error("write of one did not clear timeout");
    a_flag_keeps: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) wr_status && !hdata_s[ST_TIMEOUT]
        && !timeout_hit |=> $stable(tmo_flag))
        else $error("write of zero changed timeout");
    a_data_capture: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        wr_data |=> (data_latch == $past(hdata_s)))
        else $error("data latch missed host byte");
    a_status_hold: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) !rd_n_s && !rd_start && !rd_wait
        && addr_s == OFS_STATUS |=> $stable(host_data_out))
        else $error("status changed inside read");
    a_status_bits: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) rd_start && addr_s == OFS_STATUS |=>
        host_data_out[2:1] == 2'b00 && host_data_out[7] == !$past(busy_s))
        else $error("status bits wrong");
    a_ctrl_pins: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) wr_ctrl |=> print_pulse_pin_out ==
        !$past(hdata_s[CT_PRINT]) && printer_reinit_out ==
        $past(hdata_s[CT_REINIT]))
        else $error("control pins do not follow write");
    a_irq_edge: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        irq_out |-> $past(ctrl[CT_IRQ_ALLOW]) && $past(accept_rise))
        else $error("irq without allowed accept edge");
    a_printer_drive: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        mode_in == MODE_PRINTER |-> !port_data_lines_oe_n_out)
        else $error("printer mode released data lines");
    a_epp_gated: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) req_valid |-> is_epp)
        else $error("enhanced cycle outside enhanced mode");
endmodule

/* ppc_pkg.sv */
// shared constants and types for the parallel port register core
package ppc_pkg;
    // byte port offsets from the base address
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_STATUS = 3'h1;
    localparam logic [2:0] OFS_CTRL   = 3'h2;
    localparam logic [2:0] OFS_EADDR  = 3'h3;
    localparam logic [2:0] OFS_EDATA0 = 3'h4;
    localparam logic [2:0] OFS_EDATA3 = 3'h7;
    // status port bit positions
    localparam int ST_TIMEOUT   = 0;
    localparam int ST_FAULT     = 3;
    localparam int ST_ONLINE    = 4;
    localparam int ST_PAPER_OUT = 5;
    localparam int ST_ACCEPT    = 6;
    localparam int ST_NOT_OCC   = 7;
    // control port bit positions
    localparam int CT_PRINT     = 0;
    localparam int CT_LINE_ADV  = 1;
    localparam int CT_REINIT    = 2;
    localparam int CT_CHOOSE    = 3;
    localparam int CT_IRQ_ALLOW = 4;
    localparam int CT_DIR       = 5;
    localparam int CT_WIDTH     = 6;
    // reset values, and the byte read from an unmapped port
    localparam logic [7:0]          DATA_RST  = 8'h00;
    localparam logic [CT_WIDTH-1:0] CTRL_RST  = 6'h00;
    localparam logic [7:0]          UNMAP_RD  = 8'hff;
    // buffer entry: {address cycle, write cycle, byte}
    localparam int ENT_W = 10;
    // watchdog on an enhanced cycle
    localparam int CLK_PERIOD_NS = 100;
    localparam int TIMEOUT_NS    = 10000;
    // longest time rounds down, never below one cycle
    localparam int TIMEOUT_RAW  = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYC  = (TIMEOUT_RAW < 1) ? 1 : TIMEOUT_RAW;
    localparam int TCNT_W       = 8;
    localparam logic [TCNT_W-1:0] TIMEOUT_LAST =
        TCNT_W'(TIMEOUT_CYC - 1);
    // port operating modes
    typedef enum logic [1:0] {
        MODE_PRINTER = 2'b00,
        MODE_BIDIR   = 2'b01,
        MODE_EPP     = 2'b10,
        MODE_ECP     = 2'b11
    } ppc_mode_t;
    // enhanced cycle engine states
    typedef enum logic [1:0] {
        ES_IDLE   = 2'b00,
        ES_STROBE = 2'b01,
        ES_FINISH = 2'b10
    } ppc_eng_t;
    // offsets that only exist in enhanced mode
    function automatic logic epp_only(input logic [2:0] ofs);
        epp_only = (ofs >= OFS_EADDR);
    endfunction
endpackage

/* ppc_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module ppc_sync #(
    parameter int         W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta; // first stage, read only by the second

    // first stage catches the pin, second feeds logic
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            meta     <= INIT;
            sync_out <= INIT;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* ppc_buf2.sv */
// two-entry valid/ready buffer for enhanced cycle requests
`timescale 1ns/1ns
module ppc_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic      [W-1:0] out_data_out
);
    logic [W-1:0] mem [2]; // storage words
    logic         rd_ptr;  // head slot
    logic         wr_ptr;  // tail slot
    logic [1:0]   count;   // words held
    logic         push;
    logic         pop;

    assign in_ready_out  = (count != 2'd2);
    assign out_valid_out = (count != 2'd0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem[rd_ptr];

    // storage write, no reset needed on data
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* ppc_printer_model.sv */
// printer side model: resolved data lines and enhanced handshake
`timescale 1ns/1ns
module ppc_printer_model (
    input  wire logic       clk_sys_in,
    input  wire logic       stall_in,   // never answer, forces timeout
    input  wire logic [2:0] lat_in,     // clocks before wait rises
    input  wire logic [7:0] drive_in,   // byte the printer drives back
    input  wire logic [7:0] core_data_in,
    input  wire logic       core_oe_n_in,
    input  wire logic       data_strobe_n_in,
    input  wire logic       addr_strobe_n_in,
    input  wire logic       write_n_in,
    output logic      [7:0] wire_out,
    output logic            wait_n_out,
    output logic      [7:0] got_out     // last byte taken on a write
);
    logic [2:0] dly = 3'h0;
    wire        act = !data_strobe_n_in || !addr_strobe_n_in;
    initial wait_n_out = 1'b0;
    initial got_out = 8'h00;
    // core drives when enabled, otherwise the printer drives its byte
    assign wire_out = core_oe_n_in ? drive_in : core_data_in;
    // wait low at idle, rises some clocks into a strobe, falls after
    always @(posedge clk_sys_in) begin
        if (!act) begin
            dly <= 3'h0;
            wait_n_out <= 1'b0;
        end else if (dly != lat_in) begin
            dly <= dly + 3'h1;
        end else if (!stall_in) begin
            wait_n_out <= 1'b1;
            // a write strobe hands its byte over
            if (!write_n_in)
                got_out <= core_data_in;
        end
    end
endmodule

/* ppc_core_tb_top.sv */
// self-checking bench for the parallel port register core
`timescale 1ns/1ns
module ppc_core_tb_top;
    import ppc_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       rst_n_in = 1'b0;
    ppc_mode_t  mode_in = MODE_PRINTER;
    logic [2:0] host_addr_in = 3'h0;
    logic [7:0] host_data_in = 8'h00;
    logic [7:0] host_data_out, port_data_lines_in, port_data_lines_out;
    logic       host_write_strobe_n_in = 1'b1;
    logic       host_read_strobe_n_in = 1'b1;
    logic       printer_fault_pin_in = 1'b0, online_in = 1'b0;
    logic       paper_out_in = 1'b0, char_accept_in = 1'b0, busy_in = 1'b0;
    logic       host_data_oe_n_out, host_ready_out, irq_out, epp_wait_n_in;
    logic       port_data_lines_oe_n_out, print_pulse_pin_out;
    logic       line_advance_pin_out, printer_reinit_out;
    logic       device_choose_pin_out, epp_data_strobe_n_out;
    logic       epp_addr_strobe_n_out, epp_write_n_out;
    logic [7:0] pdrv = 8'hc3, got, rd;
    logic [2:0] lat = 3'h1;
    logic       stall = 1'b0;
    int         n_errors = 0, compares = 0, n_irq = 0, cyc = 0;
    wire  [7:0] pins = {4'h0, print_pulse_pin_out, line_advance_pin_out,
                        printer_reinit_out, device_choose_pin_out};
    always #50 clk_sys_in = ~clk_sys_in;
    // host ready is wired straight back to the bus tasks
    ppc_core u_dut (.*);
    ppc_printer_model u_prn (
        .clk_sys_in       (clk_sys_in),
        .stall_in         (stall),
        .lat_in           (lat),
        .drive_in         (pdrv),
        .core_data_in     (port_data_lines_out),
        .core_oe_n_in     (port_data_lines_oe_n_out),
        .data_strobe_n_in (epp_data_strobe_n_out),
        .addr_strobe_n_in (epp_addr_strobe_n_out),
        .write_n_in       (epp_write_n_out),
        .wire_out         (port_data_lines_in),
        .wait_n_out       (epp_wait_n_in),
        .got_out          (got)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // cycle ceiling, irq pulse count
    always @(posedge clk_sys_in) begin
        cyc++;
        if (irq_out === 1'b1)
            n_irq++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    // inputs always move a fixed 10 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #10;
    endtask
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        compares++;
        if (got_v !== exp_v) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got_v, exp_v);
        end
    endtask
    // bounded wait; a stuck ready counts as an error, not a compare
    task automatic wait_rdy();
        int k;
        k = 0;
        while (host_ready_out !== 1'b1 && k < 300) begin
            tick(1);
            k++;
        end
        if (k == 300)
            n_errors++;
    endtask
    // strobe is held until ready before release
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_addr_in = a;
        host_data_in = d;
        host_write_strobe_n_in = 1'b0;
        tick(4);
        wait_rdy();
        host_write_strobe_n_in = 1'b1;
        tick(6);
    endtask
    task automatic rd_b(input logic [2:0] a);
        host_addr_in = a;
        host_read_strobe_n_in = 1'b0;
        tick(4);
        wait_rdy();
        tick(2);
        rd = host_data_out;
        host_read_strobe_n_in = 1'b1;
        tick(4);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        rd_b(a);
        chk(rd, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        rst_n_in = 1'b1;
        tick(4);
        chk(port_data_lines_out, DATA_RST);
        chk(pins, 8'h0d);
        rc(OFS_CTRL, 8'h00);
        $display("test reset done");
        wr(OFS_DATA, 8'h5a);
        chk(port_data_lines_out, 8'h5a);
        rc(OFS_DATA, 8'h5a);
        wr(OFS_CTRL, 8'hff);
        rc(OFS_CTRL, 8'h3f);
        chk(pins, 8'h02);
        chk({7'h00, port_data_lines_oe_n_out}, 8'h00);
        mode_in = MODE_BIDIR;
        tick(2);
        rc(OFS_DATA, 8'hc3);
        rc(OFS_EADDR, UNMAP_RD);
        $display("test ports done");
        printer_fault_pin_in = 1'b1;
        paper_out_in = 1'b1;
        busy_in = 1'b1;
        tick(4);
        rc(OFS_STATUS, 8'h28);
        // pins move in mid-read, the held byte must not
        host_addr_in = OFS_STATUS;
        host_read_strobe_n_in = 1'b0;
        tick(5);
        busy_in = 1'b0;
        online_in = 1'b1;
        tick(6);
        chk(host_data_out, 8'h28);
        chk({7'h00, host_data_oe_n_out}, 8'h00);
        host_read_strobe_n_in = 1'b1;
        tick(4);
        chk({7'h00, host_data_oe_n_out}, 8'h01);
        rc(OFS_STATUS, 8'hb8);
        $display("test status done");
        char_accept_in = 1'b1;
        tick(8);
        chk(8'(n_irq), 8'h01);
        rc(OFS_STATUS, 8'hf8);
        wr(OFS_CTRL, 8'h04);
        char_accept_in = 1'b0;
        tick(4);
        char_accept_in = 1'b1;
        tick(8);
        chk(8'(n_irq), 8'h01);
        $display("test irq done");
        mode_in = MODE_EPP;
        tick(2);
        wr(OFS_EDATA0, 8'h77);
        tick(20);
        chk(got, 8'h77);
        lat = 3'h6;
        wr(OFS_EADDR, 8'h31);
        tick(20);
        chk(got, 8'h31);
        // direction set to input: the write runs as a read
        wr(OFS_CTRL, 8'h24);
        wr(OFS_EDATA0, 8'h11);
        tick(20);
        chk(got, 8'h31);
        wr(OFS_CTRL, 8'h04);
        pdrv = 8'h9c;
        rc(OFS_EDATA3, 8'h9c);
        $display("test enhanced done");
        stall = 1'b1;
        rd_b(OFS_EDATA0);
        stall = 1'b0;
        rc(OFS_STATUS, 8'hf9);
        wr(OFS_STATUS, 8'h00);
        rc(OFS_STATUS, 8'hf9);
        wr(OFS_STATUS, 8'h01);
        rc(OFS_STATUS, 8'hf8);
        $display("test timeout done");
        end_sim();
    end
endmodule
